// file: lmd_pkg.sv
// package: constants and carrier types for the line mode configuration decoder
//------------------------------------------------------------
//------------------------------------------------------------
package lmd_pkg;

   localparam logic [2:0] FRAME_DS3_CBIT  = 3'h0;
   localparam logic [2:0] FRAME_DS3_M23   = 3'h1;
   localparam logic [2:0] FRAME_E3_G751   = 3'h2;
   localparam logic [2:0] FRAME_E3_G832   = 3'h3;
   localparam logic [2:0] FRAME_DS3_CLEAR = 3'h4;
   localparam logic [2:0] FRAME_E3_CLEAR  = 3'h6;

   localparam logic [2:0] LINE_BIPOLAR    = 3'h0;
   localparam logic [2:0] LINE_ATTEN_OFF  = 3'h1;
   localparam logic [2:0] LINE_ATTEN_RX   = 3'h2;
   localparam logic [2:0] LINE_ATTEN_TX   = 3'h3;
   localparam int         LINE_SINGLE_BIT = 2;

   // jitter attenuator placement
   typedef enum logic [1:0] {
      LMD_ATTEN_OFF = 2'h0,
      LMD_ATTEN_RX  = 2'h1,
      LMD_ATTEN_TX  = 2'h2
   } lmd_atten_t;

   // line coding
   typedef enum logic [1:0] {
      LMD_CODE_NONE  = 2'h0,
      LMD_CODE_SUBST = 2'h1,
      LMD_CODE_AMI   = 2'h2
   } lmd_code_t;

   // line side operating mode, one-hot
   typedef enum logic [3:0] {
      LMD_LS_IDLE    = 4'h1,
      LMD_LS_ANALOG  = 4'h2,
      LMD_LS_BIPOLAR = 4'h4,
      LMD_LS_SINGLE  = 4'h8
   } lmd_line_t;

   typedef struct packed {
      logic [2:0] frame_mode_select;
      logic [2:0] line_mode_select;
      logic       tx_zero_suppress_disable;
      logic       rx_zero_suppress_disable;
      logic       line_interface_bypass;
      logic       rate_adapter_is_tx_clock;
   } lmd_cfg_t;

   typedef struct packed {
      lmd_line_t  line_state;
      logic       framed;
      logic       unframed;
      logic       is_e3;
      logic       rate_adapter_en;
      logic       rate_adapter_e3;
      logic       analog_line_unit_en;
      logic       analog_line_unit_e3;
      lmd_atten_t jitter_attenuator;
      lmd_code_t  tx_code;
      lmd_code_t  rx_code;
      logic       subst_hdb3;
      logic       framer_rst;
      logic       line_rst;
      logic       analog_rst;
      logic       atten_rst;
      logic       config_error;
   } lmd_sel_t;

   localparam lmd_sel_t SEL_RESET = '{
      line_state:          LMD_LS_IDLE,
      framed:              1'b0,
      unframed:            1'b0,
      is_e3:               1'b0,
      rate_adapter_en:     1'b0,
      rate_adapter_e3:     1'b0,
      analog_line_unit_en: 1'b0,
      analog_line_unit_e3: 1'b0,
      jitter_attenuator:   LMD_ATTEN_OFF,
      tx_code:             LMD_CODE_NONE,
      rx_code:             LMD_CODE_NONE,
      subst_hdb3:          1'b0,
      framer_rst:          1'b1,
      line_rst:            1'b1,
      analog_rst:          1'b1,
      atten_rst:           1'b1,
      config_error:        1'b0
   };

endpackage

// file: lmd_decoder.sv
// module: registered decode of frame and line mode into block selects
`timescale 1ns/100ps
module lmd_decoder (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire lmd_pkg::lmd_cfg_t cfg,
   output lmd_pkg::lmd_sel_t      sel
);

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   function automatic lmd_pkg::lmd_code_t code_of(input logic dis, input logic active);
      if (!active) begin
         code_of = lmd_pkg::LMD_CODE_NONE;
      end else if (dis) begin
         code_of = lmd_pkg::LMD_CODE_AMI;
      end else begin
         code_of = lmd_pkg::LMD_CODE_SUBST;
      end
   endfunction

   //------------------------------------------------------------
   // combinational decode
   //------------------------------------------------------------
   lmd_pkg::lmd_sel_t sel_next;
   logic              code_framed;
   logic              code_clear;
   logic              code_e3;
   logic              coded;

   always_comb begin
      code_framed = (cfg.frame_mode_select <= lmd_pkg::FRAME_E3_G832);
      code_clear  = (cfg.frame_mode_select == lmd_pkg::FRAME_DS3_CLEAR) ||
                    (cfg.frame_mode_select == lmd_pkg::FRAME_E3_CLEAR);
      // g.751 and g.832 are the e3 framings; 110 the e3 clear channel
      code_e3     = (cfg.frame_mode_select == lmd_pkg::FRAME_E3_G751) ||
                    (cfg.frame_mode_select == lmd_pkg::FRAME_E3_G832) ||
                    (cfg.frame_mode_select == lmd_pkg::FRAME_E3_CLEAR);
      sel_next              = lmd_pkg::SEL_RESET;
      sel_next.framed       = code_framed;
      sel_next.unframed     = code_clear;
      sel_next.is_e3        = code_e3;
      coded                 = 1'b0;
      // reserved frame codes leave everything at the reset selects except config_error, which is set
      if (code_framed || code_clear) begin
         sel_next.framer_rst = !code_framed;
         if (cfg.line_mode_select[lmd_pkg::LINE_SINGLE_BIT]) begin
            // single rail ignores the suppress bits, needs bypass set
            if (cfg.line_interface_bypass) begin
               sel_next.line_state = lmd_pkg::LMD_LS_SINGLE;
               sel_next.line_rst   = 1'b0;
            end else begin
               sel_next.config_error = 1'b1;
            end
         end else if (cfg.line_mode_select == lmd_pkg::LINE_BIPOLAR) begin
            if (cfg.line_interface_bypass) begin
               sel_next.line_state = lmd_pkg::LMD_LS_BIPOLAR;
               sel_next.line_rst   = 1'b0;
               coded               = 1'b1;
            end else begin
               sel_next.config_error = 1'b1;
            end
         end else if (!cfg.line_interface_bypass) begin
            sel_next.line_state          = lmd_pkg::LMD_LS_ANALOG;
            sel_next.line_rst            = 1'b0;
            sel_next.analog_rst          = 1'b0;
            sel_next.analog_line_unit_en = 1'b1;
            sel_next.analog_line_unit_e3 = code_e3;
            coded                        = 1'b1;
            case (cfg.line_mode_select)
               lmd_pkg::LINE_ATTEN_RX: begin
                  sel_next.jitter_attenuator = lmd_pkg::LMD_ATTEN_RX;
                  sel_next.atten_rst         = 1'b0;
               end
               lmd_pkg::LINE_ATTEN_TX: begin
                  sel_next.jitter_attenuator = lmd_pkg::LMD_ATTEN_TX;
                  sel_next.atten_rst         = 1'b0;
               end
               default: begin
                  sel_next.jitter_attenuator = lmd_pkg::LMD_ATTEN_OFF;
               end
            endcase
         end else begin
            sel_next.config_error = 1'b1;
         end
         // mixed suppress bits are undefined; flagged, coding still per direction
         if (coded && (cfg.tx_zero_suppress_disable != cfg.rx_zero_suppress_disable)) begin
            sel_next.config_error = 1'b1;
         end
         sel_next.tx_code    = code_of(cfg.tx_zero_suppress_disable, coded);
         sel_next.rx_code    = code_of(cfg.rx_zero_suppress_disable, coded);
         sel_next.subst_hdb3 = coded && code_e3;
         // the analog unit always needs the adapter; bypassed modes when framed or
         // when it clocks the transmit side; an idle line leaves it powered down
         if (sel_next.line_state == lmd_pkg::LMD_LS_ANALOG) begin
            sel_next.rate_adapter_en = 1'b1;
         end else if (sel_next.line_state != lmd_pkg::LMD_LS_IDLE) begin
            sel_next.rate_adapter_en = code_framed || cfg.rate_adapter_is_tx_clock;
         end
         sel_next.rate_adapter_e3 = sel_next.rate_adapter_en && code_e3;
         if (sel_next.line_state == lmd_pkg::LMD_LS_IDLE) begin
            sel_next.framer_rst = 1'b1;
         end
      end else begin
         sel_next.config_error = 1'b1;
      end
   end

   //------------------------------------------------------------
   // output register
   //------------------------------------------------------------
   // registered so downstream power and reset gates never see decode glitches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel <= lmd_pkg::SEL_RESET;
      end else begin
         sel <= sel_next;
      end
   end

endmodule

// file: lmd_decoder_chk.sv
// checker: decode relations between cfg and sel
`timescale 1ns/100ps
module lmd_decoder_chk (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire lmd_pkg::lmd_cfg_t cfg,
   input wire lmd_pkg::lmd_sel_t sel
);
   lmd_pkg::lmd_cfg_t pc_reg;
   logic              ok_reg;
   logic [2:0]        fsel;
   logic [2:0]        lsel;
   logic              zs;
   logic              ze;
   logic              lg;
   logic              an;
   // ok_reg masks the first edge after reset, when sel still holds reset values
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ok_reg <= 1'b0;
      else ok_reg <= 1'b1;
   end
   always_ff @(posedge clk) begin
      pc_reg <= cfg;
   end
   assign fsel = pc_reg.frame_mode_select;
   assign lsel = pc_reg.line_mode_select;
   assign zs = pc_reg.tx_zero_suppress_disable;
   assign ze = zs == pc_reg.rx_zero_suppress_disable;
   assign lg = ok_reg && !(fsel[2] && fsel[0]) && pc_reg.line_interface_bypass == (lsel == 3'h0 || lsel[2]);
   assign an = lg && lsel != 3'h0 && !lsel[2] && fsel[2];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   unfr_mode_a: assert property (an |-> sel.unframed && !sel.framed)
      else $error("unframed decode wrong");
   unfr_rate_a: assert property (an |-> sel.rate_adapter_e3 == fsel[1] && sel.analog_line_unit_e3 == fsel[1])
      else $error("unframed rate wrong");
   atten_place_a: assert property (lg && lsel != 3'h0 && !lsel[2] |-> sel.jitter_attenuator == lsel[1:0] - 2'h1)
      else $error("attenuator place wrong");
   code_sel_a: assert property (lg && !lsel[2] && ze |-> sel.rx_code == (zs ? 2'h2 : 2'h1))
      else $error("line code wrong");
   bip_mode_a: assert property (lg && lsel == 3'h0 |-> sel.line_state == 4'h4 && !sel.analog_line_unit_en)
      else $error("bipolar mode wrong");
   bip_rate_a: assert property (lg && lsel == 3'h0 && fsel[2] && !zs && ze |->
      sel.rate_adapter_en == pc_reg.rate_adapter_is_tx_clock && sel.subst_hdb3 == fsel[1])
      else $error("bipolar rate wrong");
   uni_mode_a: assert property (lg && lsel[2] |-> sel.line_state == 4'h8 && sel.tx_code == 2'h0)
      else $error("single rail wrong");
   uni_rate_a: assert property (lg && lsel[2] && fsel[2] |-> sel.rate_adapter_en == pc_reg.rate_adapter_is_tx_clock)
      else $error("single rail rate wrong");
   unused_rst_a: assert property (ok_reg |-> sel.framer_rst == (!sel.framed || sel.line_state == 4'h1) &&
      sel.analog_rst == !sel.analog_line_unit_en)
      else $error("unused reset wrong");
   rsvd_frame_a: assert property (ok_reg && fsel[2] && fsel[0] |-> sel.config_error && sel.line_rst)
      else $error("reserved code wrong");
endmodule
bind lmd_decoder lmd_decoder_chk lmd_decoder_chk_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .sel(sel));

// file: lmd_line_model.sv
// model: far-side line unit, reports when its rails are live
`timescale 1ns/100ps
module lmd_line_model (
   input  wire logic              clk,
   input  wire lmd_pkg::lmd_sel_t sel,
   output logic                   rails_live
);
   // rails only live once the line path leaves reset in an external mode
   always_ff @(posedge clk) begin
      rails_live <= !sel.line_rst && sel.line_state[3:2] != 2'h0;
   end
endmodule

// file: lmd_decoder_tb_top.sv
// testbench: drives mode settings and checks decoded selects
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module lmd_decoder_tb_top;
   logic              clk;
   logic              rst_n;
   lmd_pkg::lmd_cfg_t cfg;
   lmd_pkg::lmd_sel_t sel;
   logic              rails_live;
   int                num_errors = 0;
   int                check_count = 0;
   lmd_decoder lmd_decoder_i (.clk(clk), .rst_n(rst_n), .cfg(cfg), .sel(sel));
   lmd_line_model lmd_line_model_i (.clk(clk), .sel(sel), .rails_live(rails_live));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic put(input logic [2:0] f, l, input logic [1:0] z, input logic b, t);
      @(posedge clk);
      cfg <= '{f, l, z[1], z[0], b, t};
      @(posedge clk);
      #1;
   endtask
   task give_verdict;
      if (num_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // whole run is near 76 cycles; the watchdog allows about twelve times that
   initial begin
      repeat (900) @(posedge clk);
      num_errors++;
      give_verdict;
   end
   initial begin
      rst_n = 1'b0;
      cfg = '0;
      repeat (6) @(posedge clk);
      `CHK(sel, lmd_pkg::SEL_RESET)
      rst_n <= 1'b1;
      for (int f = 4; f <= 6; f += 2)
         for (int l = 1; l <= 3; l++)
            for (int z = 0; z <= 3; z += 3) begin
               put(f[2:0], l[2:0], z[1:0], 1'b0, 1'b0);
               `CHK(sel.unframed, 1'b1)
               `CHK(sel.is_e3, f[1])
               `CHK(sel.analog_line_unit_en, 1'b1)
               `CHK(sel.analog_line_unit_e3, f[1])
               `CHK(sel.rate_adapter_e3, f[1])
               `CHK(sel.subst_hdb3, f[1])
               `CHK(sel.jitter_attenuator, l[1:0] - 2'h1)
               `CHK(sel.config_error, 1'b0)
               `CHK(rails_live, 1'b0)
               `CHK(sel.tx_code, z ? 2'h2 : 2'h1)
               `CHK(sel.rx_code, z ? 2'h2 : 2'h1)
               `CHK(sel.framer_rst, 1'b1)
               `CHK(sel.atten_rst, l == 1)
            end
      put(3'h4, 3'h1, 2'h1, 1'b0, 1'b0);
      `CHK(sel.config_error, 1'b1)
      `CHK(sel.tx_code, 2'h1)
      `CHK(sel.rx_code, 2'h2)
      for (int f = 4; f <= 6; f += 2)
         for (int t = 0; t <= 1; t++) begin
            put(f[2:0], 3'h0, 2'h0, 1'b1, t[0]);
            `CHK(sel.line_state, 4'h4)
            `CHK(sel.analog_line_unit_en, 1'b0)
            `CHK(sel.rate_adapter_en, t[0])
            `CHK(sel.rate_adapter_e3, f[1] & t[0])
            `CHK(sel.subst_hdb3, f[1])
            `CHK(sel.tx_code, 2'h1)
            @(posedge clk);
            #1;
            `CHK(rails_live, 1'b1)
         end
      put(3'h4, 3'h0, 2'h0, 1'b0, 1'b0);
      `CHK(sel.config_error, 1'b1)
      `CHK(sel.line_state, 4'h1)
      put(3'h0, 3'h0, 2'h3, 1'b1, 1'b0);
      `CHK(sel.tx_code, 2'h2)
      `CHK(sel.framer_rst, 1'b0)
      put(3'h2, 3'h3, 2'h0, 1'b0, 1'b0);
      `CHK(sel.framed, 1'b1)
      `CHK(sel.framer_rst, 1'b0)
      `CHK(sel.jitter_attenuator, 2'h2)
      `CHK(sel.subst_hdb3, 1'b1)
      for (int l = 4; l <= 7; l++) begin
         put(3'h6, l[2:0], 2'h2, 1'b1, l[0]);
         `CHK(sel.line_state, 4'h8)
         `CHK(sel.config_error, 1'b0)
         `CHK(sel.tx_code, 2'h0)
         `CHK(sel.rx_code, 2'h0)
         `CHK(sel.rate_adapter_en, l[0])
         @(posedge clk);
         #1;
         `CHK(rails_live, 1'b1)
      end
      put(3'h6, 3'h4, 2'h0, 1'b0, 1'b0);
      `CHK(sel.config_error, 1'b1)
      for (int f = 5; f <= 7; f += 2) begin
         put(f[2:0], 3'h1, 2'h0, 1'b0, 1'b0);
         `CHK(sel.config_error, 1'b1)
         `CHK(sel.line_rst, 1'b1)
         `CHK(sel.unframed, 1'b0)
         @(posedge clk);
         #1;
         `CHK(rails_live, 1'b0)
      end
      put(3'h0, 3'h1, 2'h0, 1'b1, 1'b0);
      `CHK(sel.config_error, 1'b1)
      `CHK(sel.framer_rst, 1'b1)
      @(posedge clk);
      rst_n <= 1'b0;
      #1;
      `CHK(sel, lmd_pkg::SEL_RESET)
      @(posedge clk);
      rst_n <= 1'b1;
      put(3'h6, 3'h2, 2'h0, 1'b0, 1'b0);
      `CHK(sel.jitter_attenuator, 2'h1)
      give_verdict;
   end
endmodule
